/* File: core/pmic_enable_config_registers.sv */
// Enable and configuration registers of the power-management device,
// with push-button reset timer and power-good delay.
// Assumes an I2C front end that presents decoded single-byte accesses
// on the reg_* port, and a sequencer and supervisor on the same clock.
//
// Contract
// - Output bit 6 zero pulls second pin low
// - Warm-reset select makes second level bit inert
// - Output bit 4 zero pulls first pin low
// - Pin-function select makes first level bit inert
// - Bit 3 switches load switch, resets off
// - Bit 0 enables LDO; sequencer updates it
// - Bit 7 selects push-button hold 8/15 s
// - Power-good delay field decodes 10/20/50/150 ms
// - Delay applies only to power-good rising
// - Strictness zero: wide limits, no overvoltage
// - Strictness one (reset): tight limits, overvoltage
// - Warm-reset select sets second pin role
// - Current-limit field decodes 100/200/500/1000 mA
// - Output-enable register at 0x12, zero, protected
`default_nettype none
module pmic_enable_config_registers
   import pmic_cfg_pkg::*;
#(
   parameter int TICK_CLKS = pmic_cfg_pkg::TICK_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Register access from the serial front end
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   output logic            reg_ack_o,
   output logic            reg_wr_refused_o,
   // Sequencer updates of the LDO enable
   input  wire logic       seq_ldo_on_i,
   input  wire logic       seq_ldo_off_i,
   // Raw supervisor result and push-button pin
   input  wire logic       pg_raw_i,
   input  wire logic       push_button_b_i,
   // General-purpose pins, open drain
   output logic            first_gp_output_pin_o,
   output logic            first_gp_output_pin_oe_b_o,
   input  wire logic       second_gp_pin_i,
   output logic            second_gp_pin_o,
   output logic            second_gp_pin_oe_b_o,
   // Controls to the analog side
   output logic            linear_reg_on_o,
   output logic            load_switch_on_o,
   output logic      [1:0] load_switch_current_limit_o,
   output logic            supervisor_tight_sel_o,
   output logic            overvoltage_monitor_on_o,
   output logic      [1:0] undervoltage_lock_threshold_o,
   output logic            undervoltage_lock_hysteresis_o,
   output logic            warm_reset_pin_select_o,
   output logic            warm_reset_b_o,
   output logic            power_good_o,
   output logic            pb_reset_o
);
   import pmic_cfg_pkg::*;

   initial begin
      if (TICK_CLKS < 2) $error("TICK_CLKS must be at least 2");
   end

   typedef struct packed {
      logic [7:0]          output_enable_second;
      logic [7:0]          config_supervisor_timing;
      logic [7:0]          config_reset_pin_switch_limit;
      logic                unlocked;
      logic [7:0]          rdata;
      logic                ack;
      logic                refused;
      logic                pb_meta;
      logic                pb_sync;
      logic                rst_meta;
      logic                rst_sync;
      logic [MS_CNT_W-1:0] pb_cnt;
      logic                pb_fired;
      logic                pb_pulse;
      logic [PG_CNT_W-1:0] pg_cnt;
      logic                pg;
      logic                first_oe_b;
      logic                second_oe_b;
      logic                warm_rst_b;
   } state_s;

   state_s cur;
   state_s next_cur;
   logic   tick;
   logic   tick_clr;

   // Restart the millisecond base when neither timer is running, so a delay
   // begun while the other timer is idle starts on a full period and is never shorter than programmed
   assign tick_clr = cur.pb_sync & ~(pg_raw_i & ~cur.pg);

   ms_tick_div #(
      .CYCLES (TICK_CLKS)
   ) u_tick (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .clr_i   (tick_clr),
      .tick_o  (tick)
   );

   function automatic logic [PG_CNT_W-1:0] pg_delay_ms(input logic [1:0] sel);
      case (sel)
         2'b00:   pg_delay_ms = PG_CNT_W'(PG_DELAY0_MS);
         2'b01:   pg_delay_ms = PG_CNT_W'(PG_DELAY1_MS);
         2'b10:   pg_delay_ms = PG_CNT_W'(PG_DELAY2_MS);
         default: pg_delay_ms = PG_CNT_W'(PG_DELAY3_MS);
      endcase
   endfunction : pg_delay_ms

   logic                protected_hit;
   logic [1:0]          pg_sel;
   logic [MS_CNT_W-1:0] pb_hold;
   logic                first_func;
   logic                warm_sel;

   always_comb begin
      next_cur         = cur;
      next_cur.ack     = 1'b0;
      next_cur.refused = 1'b0;
      next_cur.pb_pulse = 1'b0;

      protected_hit = (reg_addr_i == ADDR_OUTPUT_ENABLE) ||
                      (reg_addr_i == ADDR_CFG_SUP) ||
                      (reg_addr_i == ADDR_CFG_RST);

      // Register writes
      if (reg_wr_i) begin
         next_cur.ack      = 1'b1;
         next_cur.unlocked = 1'b0;
         if (reg_addr_i == ADDR_PASSWORD) begin
            next_cur.unlocked = (reg_wdata_i == PASSWORD_KEY);
         end else if (protected_hit && !cur.unlocked) begin
            next_cur.refused = 1'b1;
         end else if (reg_addr_i == ADDR_OUTPUT_ENABLE) begin
            next_cur.output_enable_second = reg_wdata_i & WMASK_OUTPUT_ENABLE;
         end else if (reg_addr_i == ADDR_CFG_SUP) begin
            next_cur.config_supervisor_timing = reg_wdata_i & WMASK_CFG_SUP;
         end else if (reg_addr_i == ADDR_CFG_RST) begin
            next_cur.config_reset_pin_switch_limit = reg_wdata_i & WMASK_CFG_RST;
         end
      end

      // Sequencer wins over a host write in the same cycle
      if (seq_ldo_on_i) begin
         next_cur.output_enable_second[BIT_LINEAR_REG_ON] = 1'b1;
      end else if (seq_ldo_off_i) begin
         next_cur.output_enable_second[BIT_LINEAR_REG_ON] = 1'b0;
      end

      // Register reads; password and unmapped addresses read zero
      if (reg_rd_i) begin
         next_cur.ack = 1'b1;
         case (reg_addr_i)
            ADDR_OUTPUT_ENABLE: next_cur.rdata = cur.output_enable_second;
            ADDR_CFG_SUP:       next_cur.rdata = cur.config_supervisor_timing;
            ADDR_CFG_RST:       next_cur.rdata = cur.config_reset_pin_switch_limit;
            default:            next_cur.rdata = 8'h00;
         endcase
      end

      // Pin synchronisers
      next_cur.pb_meta  = push_button_b_i;
      next_cur.pb_sync  = cur.pb_meta;
      next_cur.rst_meta = second_gp_pin_i;
      next_cur.rst_sync = cur.rst_meta;

      // Push-button reset hold timer
      pb_hold = cur.config_supervisor_timing[BIT_PB_RESET_TIME] ?
                MS_CNT_W'(PB_HOLD_LONG_MS) : MS_CNT_W'(PB_HOLD_SHORT_MS);
      if (cur.pb_sync) begin
         next_cur.pb_cnt   = '0;
         next_cur.pb_fired = 1'b0;
      end else if (tick && !cur.pb_fired) begin
         if (cur.pb_cnt == pb_hold - MS_CNT_W'(1)) begin
            next_cur.pb_fired = 1'b1;
            next_cur.pb_pulse = 1'b1;
         end else begin
            next_cur.pb_cnt = cur.pb_cnt + MS_CNT_W'(1);
         end
      end

      // Power-good: delayed rise, immediate fall
      pg_sel = cur.config_supervisor_timing[POS_PG_DELAY +: 2];
      if (!pg_raw_i) begin
         next_cur.pg     = 1'b0;
         next_cur.pg_cnt = '0;
      end else if (!cur.pg && tick) begin
         if (cur.pg_cnt == pg_delay_ms(pg_sel) - PG_CNT_W'(1)) begin
            next_cur.pg = 1'b1;
         end else begin
            next_cur.pg_cnt = cur.pg_cnt + PG_CNT_W'(1);
         end
      end

      // Open-drain pins: enable low means pulling low
      first_func = cur.config_supervisor_timing[BIT_PIN_FUNC_SEL];
      warm_sel   = cur.config_reset_pin_switch_limit[BIT_WARM_RST_SEL];
      next_cur.first_oe_b = first_func |
                            cur.output_enable_second[BIT_FIRST_GP_LVL];
      next_cur.second_oe_b = warm_sel |
                             cur.output_enable_second[BIT_SECOND_GP_LVL];
      // Warm reset follows the pin only in its input role
      next_cur.warm_rst_b = ~warm_sel | cur.rst_sync;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cur                               <= '0;
         cur.output_enable_second          <= RST_OUTPUT_ENABLE;
         cur.config_supervisor_timing      <= RST_CFG_SUP;
         cur.config_reset_pin_switch_limit <= RST_CFG_RST;
         cur.pb_meta                       <= 1'b1;
         cur.pb_sync                       <= 1'b1;
         cur.rst_meta                      <= 1'b1;
         cur.rst_sync                      <= 1'b1;
         cur.first_oe_b                    <= 1'b1;
         cur.second_oe_b                   <= 1'b1;
         cur.warm_rst_b                    <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs straight from state flops; open-drain pin data tied low
   assign reg_rdata_o                    = cur.rdata;
   assign reg_ack_o                      = cur.ack;
   assign reg_wr_refused_o               = cur.refused;
   assign first_gp_output_pin_o          = 1'b0;
   assign first_gp_output_pin_oe_b_o     = cur.first_oe_b;
   assign second_gp_pin_o                = 1'b0;
   assign second_gp_pin_oe_b_o           = cur.second_oe_b;
   assign linear_reg_on_o                = cur.output_enable_second[BIT_LINEAR_REG_ON];
   assign load_switch_on_o               = cur.output_enable_second[BIT_LOAD_SWITCH_ON];
   assign load_switch_current_limit_o    = cur.config_reset_pin_switch_limit[POS_LS_ILIM +: 2];
   assign supervisor_tight_sel_o         = cur.config_supervisor_timing[BIT_SUP_TIGHT];
   assign overvoltage_monitor_on_o       = cur.config_supervisor_timing[BIT_SUP_TIGHT];
   assign undervoltage_lock_threshold_o  = cur.config_supervisor_timing[POS_UNDERVOLTAGE_LOCK_THRESHOLD_THRESH +: 2];
   assign undervoltage_lock_hysteresis_o = cur.config_reset_pin_switch_limit[BIT_UNDERVOLTAGE_LOCK_THRESHOLD_HYST];
   assign warm_reset_pin_select_o        = cur.config_reset_pin_switch_limit[BIT_WARM_RST_SEL];
   assign warm_reset_b_o                 = cur.warm_rst_b;
   assign power_good_o                   = cur.pg;
   assign pb_reset_o                     = cur.pb_pulse;
endmodule : pmic_enable_config_registers
`default_nettype wire

/* File: core/pmic_cfg_pkg.sv */
// Constants for the enable and configuration register bank.
// Assumes a 50 MHz system clock; register offsets are device subaddresses.
`default_nettype none
package pmic_cfg_pkg;

   // Subaddresses
   localparam logic [7:0] ADDR_PASSWORD      = 8'h10;
   localparam logic [7:0] ADDR_OUTPUT_ENABLE = 8'h12;
   localparam logic [7:0] ADDR_CFG_SUP       = 8'h13;
   localparam logic [7:0] ADDR_CFG_RST       = 8'h14;

   // Reset values
   localparam logic [7:0] RST_OUTPUT_ENABLE  = 8'h00;
   localparam logic [7:0] RST_CFG_SUP        = 8'h4c;
   localparam logic [7:0] RST_CFG_RST        = 8'hc0;

   // Writable bits; reserved read-only bits are zero here
   localparam logic [7:0] WMASK_OUTPUT_ENABLE = 8'h7f;
   localparam logic [7:0] WMASK_CFG_SUP       = 8'hff;
   localparam logic [7:0] WMASK_CFG_RST       = 8'hcf;

   // Output-enable register fields
   localparam int BIT_LINEAR_REG_ON  = 0;
   localparam int BIT_LOAD_SWITCH_ON = 3;
   localparam int BIT_FIRST_GP_LVL   = 4;
   localparam int BIT_SECOND_GP_LVL  = 6;

   // Supervisor and timing register fields
   localparam int BIT_PB_RESET_TIME  = 7;
   localparam int BIT_PIN_FUNC_SEL   = 5;
   localparam int POS_PG_DELAY       = 3;
   localparam int BIT_SUP_TIGHT      = 2;
   localparam int POS_UNDERVOLTAGE_LOCK_THRESHOLD_THRESH    = 0;

   // Reset-pin and switch-limit register fields
   localparam int BIT_WARM_RST_SEL   = 7;
   localparam int BIT_UNDERVOLTAGE_LOCK_THRESHOLD_HYST      = 6;
   localparam int POS_LS_ILIM        = 2;

   // Times
   localparam int CLK_HZ             = 50_000_000;
   localparam int TICK_US            = 1000;
   localparam int TICK_CYCLES        = (CLK_HZ / 1_000_000) * TICK_US;
   localparam int PB_HOLD_SHORT_MS   = 8000;
   localparam int PB_HOLD_LONG_MS    = 15000;
   localparam int PG_DELAY0_MS       = 10;
   localparam int PG_DELAY1_MS       = 20;
   localparam int PG_DELAY2_MS       = 50;
   localparam int PG_DELAY3_MS       = 150;

   localparam int MS_CNT_W           = 14;
   localparam int PG_CNT_W           = 8;

   // Unlock key, value arbitrary
   localparam logic [7:0] PASSWORD_KEY = 8'h5a;

endpackage : pmic_cfg_pkg
`default_nettype wire

/* File: core/ms_tick_div.sv */
// Divider giving a one-cycle enable pulse every CYCLES clocks.
// Assumes one clock domain; clearing restarts a full period.
`default_nettype none
module ms_tick_div #(
   parameter int CYCLES = 50000
) (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic clr_i,
   output logic      tick_o
);
   localparam int W = $clog2(CYCLES);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } state_s;

   state_s cur;
   state_s next_cur;

   initial begin
      if (CYCLES < 2) $error("ms_tick_div: CYCLES must be at least 2");
   end

   always_comb begin
      next_cur      = cur;
      next_cur.tick = 1'b0;
      if (clr_i) begin
         next_cur.cnt = '0;
      end else if (cur.cnt == W'(CYCLES - 1)) begin
         next_cur.cnt  = '0;
         next_cur.tick = 1'b1;
      end else begin
         next_cur.cnt = cur.cnt + W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign tick_o = cur.tick;
endmodule : ms_tick_div
`default_nettype wire

/* File: test/pmic_cfg_checker.sv */
// Port assertions for the enable and configuration register bank.
// Assumes one clock domain and one-cycle access strobes.
`default_nettype none
module pmic_cfg_checker import pmic_cfg_pkg::*; #(
   parameter int TICK_CLKS = 4
) (
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic       reg_ack_o,
   input wire logic       reg_wr_refused_o,
   input wire logic       seq_ldo_on_i,
   input wire logic       seq_ldo_off_i,
   input wire logic       pg_raw_i,
   input wire logic       first_gp_output_pin_o,
   input wire logic       second_gp_pin_o,
   input wire logic       second_gp_pin_oe_b_o,
   input wire logic       linear_reg_on_o,
   input wire logic       supervisor_tight_sel_o,
   input wire logic       overvoltage_monitor_on_o,
   input wire logic       warm_reset_pin_select_o,
   input wire logic       warm_reset_b_o,
   input wire logic       power_good_o,
   input wire logic       pb_reset_o
);
   logic        unlocked;
   logic [15:0] pg_run;
   wire logic   prot = reg_addr_i inside {ADDR_OUTPUT_ENABLE, ADDR_CFG_SUP, ADDR_CFG_RST};

   // Mirrors the one-shot unlock so refusals can be predicted
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         unlocked <= 1'b0;
         pg_run <= 16'h0000;
      end else begin
         if (reg_wr_i) begin
            unlocked <= reg_addr_i == ADDR_PASSWORD && reg_wdata_i == PASSWORD_KEY;
         end
         pg_run <= !pg_raw_i ? 16'h0000 : (&pg_run ? pg_run : pg_run + 16'h0001);
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_ack_follows_access: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
      else $error("no ack after an access");
   a_locked_write_refused: assert property (reg_wr_i && prot && !unlocked |=> reg_wr_refused_o)
      else $error("locked write not refused");
   a_unlocked_write_taken: assert property (reg_wr_i && prot && unlocked |=> !reg_wr_refused_o)
      else $error("unlocked write refused");
   a_refusal_needs_write: assert property (reg_wr_refused_o |-> $past(reg_wr_i))
      else $error("refusal without a write");
   a_seq_sets_ldo: assert property (seq_ldo_on_i |=> linear_reg_on_o)
      else $error("sequencer on ignored");
   a_seq_clears_ldo: assert property (seq_ldo_off_i && !seq_ldo_on_i |=> !linear_reg_on_o)
      else $error("sequencer off ignored");
   a_pg_fall_fast: assert property (!pg_raw_i |=> !power_good_o)
      else $error("power good fall delayed");
   a_pg_rise_late: assert property ($rose(power_good_o) |-> pg_run >= 10 * TICK_CLKS)
      else $error("power good rose too early");
   a_pin_data_low: assert property (!first_gp_output_pin_o && !second_gp_pin_o)
      else $error("open-drain data not low");
   a_warm_pin_hiz: assert property (warm_reset_pin_select_o |=> second_gp_pin_oe_b_o)
      else $error("second pin driven in warm-reset role");
   a_ov_tracks_tight: assert property (overvoltage_monitor_on_o == supervisor_tight_sel_o)
      else $error("overvoltage monitor differs from strictness");
   a_pb_single_pulse: assert property (pb_reset_o |=> !pb_reset_o)
      else $error("push-button reset wider than one cycle");
   a_warm_out_role: assert property (!warm_reset_b_o |->
      warm_reset_pin_select_o || $past(warm_reset_pin_select_o))
      else $error("warm reset while pin is an output");
endmodule : pmic_cfg_checker

bind pmic_enable_config_registers pmic_cfg_checker #(.TICK_CLKS(TICK_CLKS)) chk_u (.*);
`default_nettype wire

/* File: test/reg_host_model.sv */
// Host model issuing single-byte accesses on the decoded register port.
// Assumes strobes are taken at a rising edge and answered one cycle later.
`default_nettype none
module reg_host_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] reg_rdata_i,
   input  wire logic       reg_ack_i,
   input  wire logic       reg_wr_refused_i,
   output var  logic [7:0] reg_addr_o,
   output var  logic [7:0] reg_wdata_o,
   output var  logic       reg_wr_o,
   output var  logic       reg_rd_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic ak, output logic rf);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= w;
      reg_rd_o <= !w;
      // Strobe is a one-cycle pulse; holding it would be taken as a second access
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      // Answer stands in the cycle after the take edge; read it at the closing edge
      @(posedge clk_i);
      q = reg_rdata_i;
      ak = reg_ack_i;
      rf = reg_wr_refused_i;
      // Released bus shows the inverse so stale values cannot pass
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask : access
endmodule : reg_host_model
`default_nettype wire

/* File: test/pmic_enable_config_registers_bench.sv */
// Self-checking bench for the enable and configuration register bank.
// Assumes the host model drives the register port; ms tick cut to 4 clocks.
`default_nettype none
module pmic_enable_config_registers_bench import pmic_cfg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int T = 4;
   logic clk_i = 1'b0;
   logic rst_b_i, seq_on, seq_off, pg_raw, pb_b, gp2, ak, rf;
   wire logic [7:0] addr, wdata, rdata;
   wire logic wr, rd, ack, refused, p1, p1_oe_b, p2, p2_oe_b, ldo, ls, tight, ov, hyst;
   wire logic wsel, wrst_b, pg, pbr;
   wire logic [1:0] ilim, undervoltage_lock_threshold;
   wire logic [11:0] outs = {ldo, ls, ilim, tight, ov, undervoltage_lock_threshold, hyst, wsel, p1_oe_b, p2_oe_b};
   wire logic pin2 = p2_oe_b ? gp2 : p2;
   int num_errors = 0, comparisons = 0, cyc = 0, n;
   int pg_ms[4] = '{10, 20, 50, 150};
   int pb_ms[2] = '{PB_HOLD_SHORT_MS, PB_HOLD_LONG_MS};
   logic [31:0] seed = 32'h0000_1aaa;
   logic [7:0] e = 8'h00, c1 = 8'h4c, c2 = 8'hc0, q, a, d;
   always #10 clk_i = ~clk_i;

   reg_host_model host_u (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_ack_i(ack),
      .reg_wr_refused_i(refused), .reg_addr_o(addr), .reg_wdata_o(wdata),
      .reg_wr_o(wr), .reg_rd_o(rd));
   pmic_enable_config_registers #(.TICK_CLKS(T)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_wr_refused_o(refused),
      .seq_ldo_on_i(seq_on), .seq_ldo_off_i(seq_off), .pg_raw_i(pg_raw),
      .push_button_b_i(pb_b), .first_gp_output_pin_o(p1),
      .first_gp_output_pin_oe_b_o(p1_oe_b), .second_gp_pin_i(pin2), .second_gp_pin_o(p2),
      .second_gp_pin_oe_b_o(p2_oe_b), .linear_reg_on_o(ldo), .load_switch_on_o(ls),
      .load_switch_current_limit_o(ilim), .supervisor_tight_sel_o(tight),
      .overvoltage_monitor_on_o(ov), .undervoltage_lock_threshold_o(undervoltage_lock_threshold),
      .undervoltage_lock_hysteresis_o(hyst), .warm_reset_pin_select_o(wsel),
      .warm_reset_b_o(wrst_b), .power_good_o(pg), .pb_reset_o(pbr));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [11:0] exp_out(logic [7:0] x, logic [7:0] y, logic [7:0] z);
      return {x[0], x[3], z[3:2], y[2], y[2], y[1:0], z[6], z[7], y[5] | x[4], z[7] | x[6]};
   endfunction : exp_out
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] dt);
      host_u.access(w, ad, dt, q, ak, rf);
      chk(ak, 1'b1);
   endtask : acc
   task automatic rdc(input logic [7:0] ad, input logic [7:0] x);
      acc(1'b0, ad, 8'h00);
      chk(q, x);
   endtask : rdc
   task automatic pwr(input logic [7:0] ad, input logic [7:0] dt);
      acc(1'b1, ADDR_PASSWORD, PASSWORD_KEY);
      acc(1'b1, ad, dt);
      chk(rf, 1'b0);
   endtask : pwr
   task automatic end_sim();
      $display("errors=%0d comparisons=%0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   // Cycle ceiling sized for the short and the long push-button hold plus margin
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 97000) begin
         num_errors++;
         end_sim();
      end
   end

   initial begin
      rst_b_i = 1'b0;
      seq_on = 1'b0;
      seq_off = 1'b0;
      pg_raw = 1'b0;
      pb_b = 1'b1;
      gp2 = 1'b1;
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rdc(ADDR_OUTPUT_ENABLE, 8'h00);
      rdc(ADDR_CFG_SUP, 8'h4c);
      rdc(ADDR_CFG_RST, 8'hc0);
      chk(outs, exp_out(e, c1, c2));
      acc(1'b1, ADDR_OUTPUT_ENABLE, 8'h7f);
      chk(rf, 1'b1);
      // An unmapped write in between must use up the unlock
      acc(1'b1, ADDR_PASSWORD, PASSWORD_KEY);
      acc(1'b1, 8'h20, 8'h55);
      acc(1'b1, ADDR_CFG_RST, 8'h00);
      chk(rf, 1'b1);
      rdc(8'h20, 8'h00);
      rdc(ADDR_PASSWORD, 8'h00);
      rdc(ADDR_CFG_RST, 8'hc0);
      for (int i = 0; i < 30; i++) begin
         n = xs() % 3;
         d = 8'(xs() >> 8);
         a = ADDR_OUTPUT_ENABLE + 8'(n);
         pwr(a, d);
         if (n == 0) e = d & 8'h7f;
         else if (n == 1) c1 = d;
         else c2 = d & 8'hcf;
         rdc(a, n == 0 ? e : (n == 1 ? c1 : c2));
         chk(outs, exp_out(e, c1, c2));
      end
      for (int v = 1; v >= 0; v--) begin
         @(posedge clk_i);
         seq_on <= v[0];
         seq_off <= !v[0];
         @(posedge clk_i);
         seq_on <= 1'b0;
         seq_off <= 1'b0;
         e[0] = v[0];
         rdc(ADDR_OUTPUT_ENABLE, e);
      end
      for (int k = 0; k < 4; k++) begin
         c1[4:3] = k[1:0];
         c1[7] = 1'b0;
         pwr(ADDR_CFG_SUP, c1);
         @(posedge clk_i);
         pg_raw <= 1'b1;
         n = 0;
         while (pg !== 1'b1 && n < 1000) begin
            @(posedge clk_i);
            n++;
         end
         chk(n >= pg_ms[k] * T && n <= pg_ms[k] * T + 5, 1'b1);
         pg_raw <= 1'b0;
         @(posedge clk_i);
         #1;
         chk(pg, 1'b0);
      end
      for (int b = 0; b < 2; b++) begin
         c1[7] = b[0];
         pwr(ADDR_CFG_SUP, c1);
         @(posedge clk_i);
         pb_b <= 1'b0;
         n = 0;
         while (pbr !== 1'b1 && n < pb_ms[b] * T + 20) begin
            @(posedge clk_i);
            n++;
         end
         chk(n >= pb_ms[b] * T && n < pb_ms[b] * T + 20, 1'b1);
         pb_b <= 1'b1;
         repeat (4) @(posedge clk_i);
      end
      for (int w = 1; w >= 0; w--) begin
         c2[7] = w[0];
         pwr(ADDR_CFG_RST, c2);
         @(posedge clk_i);
         gp2 <= 1'b0;
         repeat (5) @(posedge clk_i);
         chk(wrst_b, !w[0]);
         gp2 <= 1'b1;
      end
      chk(outs, exp_out(e, c1, c2));
      end_sim();
   end
endmodule : pmic_enable_config_registers_bench
`default_nettype wire
